// ===== dv/pdci_ext_dev.sv
// far-side model: interrupt source and clock output receiver
`timescale 1ns/1ns
module pdci_ext_dev (
    input wire clk,
    input wire pull_low,
    input wire bus_clock_out,
    input wire bus_clock_oe_n,
    output logic irq_pin_n,
    output int gap
);
    int cnt = 0;
    initial irq_pin_n = 1'h1;
    initial gap = 0;
    // pin moves off the edge: it is asynchronous to the unit
    always @(posedge clk) irq_pin_n <= #7 !pull_low;
    // cycles between driven clock pulses, counting the pulse cycle itself
    always @(posedge clk) begin
        if (!bus_clock_oe_n && bus_clock_out) begin
            gap <= cnt + 1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ===== dv/pdci_port_ctrl_sva.sv
// assertion checker for the port control unit
`timescale 1ns/1ns
`include "pdci_defs.vh"
module pdci_port_ctrl_sva #(
    parameter PORT_W = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire [`PDCI_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [PORT_W-1:0] dir_a,
    input wire [PORT_W-1:0] dir_b,
    input wire [PORT_W-1:0] dir_e,
    input wire [PORT_W-1:0] dir_k,
    input wire gpio_e4_out,
    input wire gpio_e4_dir,
    input wire irq_pin_n,
    input wire [PORT_W-1:0] reduce_a,
    input wire [PORT_W-1:0] reduce_b,
    input wire [PORT_W-1:0] reduce_e,
    input wire [PORT_W-1:0] reduce_k,
    input wire bus_clock_out,
    input wire bus_clock_oe_n,
    input wire double_clock_en,
    input wire ext_irq_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_drv_wr;
        reg_wr && reg_addr == `PDCI_OFS_DRIVE;
    endsequence
    sequence s_clk_wr;
        reg_wr && reg_addr == `PDCI_OFS_CLKCTL;
    endsequence
    // shadow of the clock control register, to spot a real settings change
    logic [7:0] clk_shadow;
    always @(posedge clk) begin
        if (sys_rst) begin
            clk_shadow <= `PDCI_CLKCTL_RST;
        end else if (reg_wr && reg_addr == `PDCI_OFS_CLKCTL) begin
            clk_shadow <= reg_wdata;
        end
    end
    chk_div_restart: assert property (s_clk_wr ##0 (!reg_wdata[7]
        && reg_wdata[5:0] != clk_shadow[5:0]) |=> ##2 !bus_clock_out)
        else $error("divider did not restart on a settings change");
    chk_rsvd_zero: assert property (reg_rd && reg_addr == `PDCI_OFS_RSVD |=> reg_rdata == 8'h00)
        else $error("reserved register read nonzero");
    chk_input_no_reduce: assert property (((reduce_a & ~$past(dir_a)) | (reduce_b & ~$past(dir_b))
        | (reduce_e & ~$past(dir_e)) | (reduce_k & ~$past(dir_k))) == '0)
        else $error("reduced drive on an input pin");
    chk_drive_ab: assert property (s_drv_wr |=> ##1
        reduce_a == ($past(reg_wdata[`PDCI_DRV_A], 2) ? $past(dir_a) : '0)
        && reduce_b == ($past(reg_wdata[`PDCI_DRV_B], 2) ? $past(dir_b) : '0))
        else $error("port a or b drive select wrong");
    chk_drive_k: assert property (s_drv_wr |=> ##1
        reduce_k == ($past(reg_wdata[`PDCI_DRV_K], 2) ? $past(dir_k) : '0))
        else $error("port k drive select wrong");
    chk_drive_e: assert property (s_drv_wr |=> ##1
        reduce_e == ($past(reg_wdata[`PDCI_DRV_E], 2) ? $past(dir_e) : '0))
        else $error("port e drive select wrong");
    chk_x2_enable: assert property (s_clk_wr |=> ##1 double_clock_en == !$past(reg_wdata[6], 2))
        else $error("double clock enable wrong");
    chk_clk_enable: assert property (s_clk_wr ##0 !reg_wdata[7] |=> ##1 !bus_clock_oe_n)
        else $error("clock output not driving");
    chk_pin_handover: assert property (bus_clock_oe_n && !$past(sys_rst) |->
        !$past(gpio_e4_dir) && bus_clock_out == $past(gpio_e4_out))
        else $error("shared pin not following general io");
    chk_irq_cause: assert property ($rose(ext_irq_req) |-> !($past(irq_pin_n, 2)
        && $past(irq_pin_n, 3) && $past(irq_pin_n, 4) && $past(irq_pin_n, 5)))
        else $error("request without a low pin");
endmodule

bind pdci_port_ctrl pdci_port_ctrl_sva #(.PORT_W(PORT_W)) u_sva (.clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dir_a, .dir_b, .dir_e, .dir_k, .gpio_e4_out,
    .gpio_e4_dir, .irq_pin_n, .reduce_a, .reduce_b, .reduce_e, .reduce_k, .bus_clock_out,
    .bus_clock_oe_n, .double_clock_en, .ext_irq_req);

// ===== dv/tb_port_drive_clkout_irq_control.sv
// self-checking bench for the port control unit
`timescale 1ns/1ns
`include "pdci_defs.vh"
module tb_port_drive_clkout_irq_control;
    logic clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, special_mode = 1'h0;
    logic gpio_e4_out = 1'h0, gpio_e4_dir = 1'h0, irq_service = 1'h0, pull_low = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, dir_a = 8'h00, dir_b = 8'h00, dir_e = 8'h00, dir_k = 8'h00, d;
    logic [7:0] reg_rdata, reduce_a, reduce_b, reduce_e, reduce_k;
    logic bus_clock_out, bus_clock_oe_n, double_clock_en, ext_irq_req, irq, irq_pin_n;
    logic [7:0] rst_val [8] = '{8'h00, 8'hc0, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [5:0] cfg [6] = '{6'h00, 6'h01, 6'h04, 6'h1f, 6'h22, 6'h3f};
    int failures = 0, compares = 0, cycles = 0, gap, seed = 32'hcb3b;
    pdci_port_ctrl #(.PORT_W(8)) u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .special_mode, .dir_a, .dir_b, .dir_e, .dir_k, .gpio_e4_out, .gpio_e4_dir,
        .irq_pin_n, .irq_service, .reduce_a, .reduce_b, .reduce_e, .reduce_k, .bus_clock_out,
        .bus_clock_oe_n, .double_clock_en, .ext_irq_req, .irq);
    pdci_ext_dev u_dev (.clk, .pull_low, .bus_clock_out, .bus_clock_oe_n, .irq_pin_n, .gap);
    initial forever #50 clk = ~clk;
    function automatic logic [7:0] red(input logic s, input logic [7:0] dr);
        return s ? dr : 8'h00;
    endfunction
    function automatic int period(input logic [4:0] dv, input logic p);
        return (dv + 1) * (p ? 16 : 1);
    endfunction
    task automatic tally_and_finish;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // whole run needs about 2000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(16'(reg_rdata), 16'(e));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 8; i++) rd(i[2:0], rst_val[i]);
        wr(`PDCI_OFS_RSVD, 8'hff);
        wr(3'h6, 8'hff);
        rd(`PDCI_OFS_RSVD, 8'h00);
        $display("test reset_map done");
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 8'hff : 8'($random(seed));
            @(posedge clk);
            {dir_a, dir_b, dir_e, dir_k} <= (i == 0) ? 32'hffff_ffff : $random(seed);
            wr(`PDCI_OFS_DRIVE, d);
            cyc(2);
            chk(16'(reduce_k), 16'(red(d[7], dir_k)));
            chk(16'(reduce_e), 16'(red(d[4], dir_e)));
            chk(16'(reduce_b), 16'(red(d[1], dir_b)));
            chk(16'(reduce_a), 16'(red(d[0], dir_a)));
            rd(`PDCI_OFS_DRIVE, d & `PDCI_DRV_MASK);
        end
        $display("test drive done");
        @(posedge clk) gpio_e4_out <= 1'h1;
        cyc(2);
        chk(16'(bus_clock_out), 16'h1);
        for (int i = 0; i < 6; i++) begin
            d = {1'h0, 1'($random(seed)), cfg[i]};
            wr(`PDCI_OFS_CLKCTL, d);
            cyc(3 * period(d[4:0], d[5]) + 4);
            chk(16'(gap), 16'(period(d[4:0], d[5])));
            chk(16'(double_clock_en), 16'(!d[6]));
            chk(16'(bus_clock_oe_n), 16'h0);
        end
        $display("test clock_out done");
        wr(`PDCI_OFS_IRQ_MASK, 8'h03);
        @(posedge clk) pull_low <= 1'h1;
        cyc(8);
        chk(16'(ext_irq_req), 16'h1);
        chk(16'(irq), 16'h1);
        rd(`PDCI_OFS_IRQ_STAT, 8'h02);
        @(posedge clk) pull_low <= 1'h0;
        cyc(8);
        chk(16'(ext_irq_req), 16'h0);
        wr(`PDCI_OFS_IRQ_MASK, 8'h00);
        cyc(3);
        chk(16'(irq), 16'h0);
        wr(`PDCI_OFS_IRQ_STAT, 8'h03);
        wr(`PDCI_OFS_IRQ_MASK, 8'h03);
        wr(`PDCI_OFS_EXT_INTERRUPT_CONTROL, 8'hc0);
        @(posedge clk) pull_low <= 1'h1;
        repeat (3) @(posedge clk);
        pull_low <= 1'h0;
        cyc(10);
        chk(16'(ext_irq_req), 16'h1);
        chk(16'(irq), 16'h1);
        @(posedge clk) irq_service <= 1'h1;
        @(posedge clk) irq_service <= 1'h0;
        cyc(3);
        chk(16'(ext_irq_req), 16'h0);
        rd(`PDCI_OFS_IRQ_STAT, 8'h01);
        wr(`PDCI_OFS_IRQ_STAT, 8'h03);
        wr(`PDCI_OFS_EXT_INTERRUPT_CONTROL, 8'h40);
        rd(`PDCI_OFS_EXT_INTERRUPT_CONTROL, 8'hc0);
        @(posedge clk) special_mode <= 1'h1;
        wr(`PDCI_OFS_EXT_INTERRUPT_CONTROL, 8'h00);
        rd(`PDCI_OFS_EXT_INTERRUPT_CONTROL, 8'h00);
        @(posedge clk) pull_low <= 1'h1;
        cyc(8);
        chk(16'(ext_irq_req), 16'h0);
        rd(`PDCI_OFS_IRQ_STAT, 8'h00);
        $display("test irq_pin done");
        tally_and_finish();
    end
endmodule

// ===== pkg/pdci_defs.vh
// register offsets, field positions and reset values for the port control unit
`ifndef PDCI_DEFS_VH
`define PDCI_DEFS_VH

`define PDCI_ADDR_W 3
`define PDCI_OFS_DRIVE 3'h0
`define PDCI_OFS_CLKCTL 3'h1
`define PDCI_OFS_RSVD 3'h2
`define PDCI_OFS_EXT_INTERRUPT_CONTROL 3'h3
`define PDCI_OFS_IRQ_STAT 3'h4
`define PDCI_OFS_IRQ_MASK 3'h5

`define PDCI_DRV_K 7
`define PDCI_DRV_E 4
`define PDCI_DRV_B 1
`define PDCI_DRV_A 0
`define PDCI_DRV_MASK 8'h93

`define PDCI_CLK_OFF 7
`define PDCI_X2_OFF 6
`define PDCI_PRESCALE 5
`define PDCI_DIV_HI 4
`define PDCI_DIV_LO 0

`define PDCI_IRQ_EDGE 7
`define PDCI_IRQ_CONN 6

`define PDCI_DRIVE_RST 8'h00
`define PDCI_CLKCTL_RST 8'hc0
`define PDCI_EXT_INTERRUPT_CONTROL_RST 8'h40
`define PDCI_ZERO8 8'h00
`define PDCI_PRESCALE_LAST 4'hf

`define PDCI_ST_EDGE 0
`define PDCI_ST_LEVEL 1

`endif

// ===== rtl/pdci_port_ctrl.v
// drive select, clock output divider and external interrupt pin control
// Functional notes
// - a port with reduced drive selected drives its outputs at about one fifth strength.
// - a reduced-drive bit has no effect on pins of its port configured as inputs.
// - reduced drive applies whether the pin serves general I/O or an alternative function; here gated by the dir inputs only, not by bus_clock_oe_n.
// - drive register bit 7 selects reduced drive for port K outputs.
// - drive register bit 4 selects reduced drive for port E outputs.
// - drive register bit 1 controls port B and bit 0 controls port A, one meaning reduced.
// - clock control bit 7 set disables the bus clock output, clear enables it.
// - clock control bit 6 set disables the double-rate clock output, clear enables it.
// - clock control bits 4 to 0 divide the bus clock by the field value plus one.
// - clock control bit 5 set adds a divide-by-16 stage after the field divider.
// - the reserved register reads zero and ignores writes.
// - the edge-select bit is writable once after reset in normal mode, always in special mode.
// - with edge select set a falling edge on the pin is held until reset or service.
// - with edge select clear the request is recognised while the pin is low.
// - interrupt control bit 6 connects the pin to the interrupt logic, read and write anytime.
// - an enabled bus clock output overrides general I/O use of its shared pin.
`timescale 1ns/1ns
`include "pdci_defs.vh"

module pdci_port_ctrl #(
    parameter PORT_W = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire [`PDCI_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire special_mode,
    input wire [PORT_W-1:0] dir_a,
    input wire [PORT_W-1:0] dir_b,
    input wire [PORT_W-1:0] dir_e,
    input wire [PORT_W-1:0] dir_k,
    input wire gpio_e4_out,
    input wire gpio_e4_dir,
    input wire irq_pin_n,
    input wire irq_service,
    output reg [PORT_W-1:0] reduce_a,
    output reg [PORT_W-1:0] reduce_b,
    output reg [PORT_W-1:0] reduce_e,
    output reg [PORT_W-1:0] reduce_k,
    output reg bus_clock_out,
    output reg bus_clock_oe_n,
    output reg double_clock_en,
    output reg ext_irq_req,
    output reg irq
);

    reg [7:0] port_drive_strength;
    reg [7:0] clock_output_control;
    reg edge_select;
    reg pin_connect;
    reg edge_written;
    reg [1:0] irq_stat;
    reg [1:0] irq_mask;
    reg pin_meta;
    reg pin_sync;
    reg pin_prev;
    reg edge_pending;
    reg [4:0] div_cnt;
    reg [3:0] pre_cnt;
    reg div_phase;
    reg [5:0] cfg_prev;
    reg [7:0] next_rdata;
    reg next_req;

    wire wr_drive = reg_wr && (reg_addr == `PDCI_OFS_DRIVE);
    wire wr_clkctl = reg_wr && (reg_addr == `PDCI_OFS_CLKCTL);
    wire wr_ext_interrupt_control = reg_wr && (reg_addr == `PDCI_OFS_EXT_INTERRUPT_CONTROL);
    wire wr_stat = reg_wr && (reg_addr == `PDCI_OFS_IRQ_STAT);
    wire wr_mask = reg_wr && (reg_addr == `PDCI_OFS_IRQ_MASK);
    wire [4:0] div_field = clock_output_control[`PDCI_DIV_HI:`PDCI_DIV_LO];
    wire prescale_on = clock_output_control[`PDCI_PRESCALE];
    wire [5:0] cfg_now = {prescale_on, div_field};
    wire fall_seen = pin_prev && !pin_sync;

    // per-pin reduced drive: only pins whose dir bit is set; the clock output enable is not looked at
    function [PORT_W-1:0] drv_gate;
        input sel;
        input [PORT_W-1:0] dir;
        begin
            drv_gate = {PORT_W{sel}} & dir;
        end
    endfunction

    // registers
    always @(posedge clk) begin
        if (sys_rst) begin
            port_drive_strength <= `PDCI_DRIVE_RST;
            clock_output_control <= `PDCI_CLKCTL_RST;
            edge_select <= 1'b0;
            pin_connect <= 1'b1;
            edge_written <= 1'b0;
            irq_mask <= 2'h0;
        end else begin
            if (wr_drive) begin
                port_drive_strength <= reg_wdata & `PDCI_DRV_MASK;
            end
            if (wr_clkctl) begin
                clock_output_control <= reg_wdata;
            end
            if (wr_ext_interrupt_control) begin
                pin_connect <= reg_wdata[`PDCI_IRQ_CONN];
                // second write in normal mode leaves the bit frozen
                if (special_mode || !edge_written) begin
                    edge_select <= reg_wdata[`PDCI_IRQ_EDGE];
                    // a special-mode write must not reopen a spent normal-mode write
                    if (!special_mode) begin
                        edge_written <= 1'b1;
                    end
                end
            end
            if (wr_mask) begin
                irq_mask <= reg_wdata[1:0];
            end
        end
    end

    // read data one cycle after the strobe; reserved and unmapped read zero
    always @* begin
        next_rdata = `PDCI_ZERO8;
        case (reg_addr)
            `PDCI_OFS_DRIVE: begin
                next_rdata = port_drive_strength;
            end
            `PDCI_OFS_CLKCTL: begin
                next_rdata = clock_output_control;
            end
            `PDCI_OFS_RSVD: begin
                next_rdata = `PDCI_ZERO8;
            end
            `PDCI_OFS_EXT_INTERRUPT_CONTROL: begin
                next_rdata[`PDCI_IRQ_EDGE] = edge_select;
                next_rdata[`PDCI_IRQ_CONN] = pin_connect;
            end
            `PDCI_OFS_IRQ_STAT: begin
                next_rdata[1:0] = irq_stat;
            end
            `PDCI_OFS_IRQ_MASK: begin
                next_rdata[1:0] = irq_mask;
            end
            default: begin
                next_rdata = `PDCI_ZERO8;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= `PDCI_ZERO8;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= `PDCI_ZERO8;
        end
    end

    // drive strength selects, per output pin
    always @(posedge clk) begin
        if (sys_rst) begin
            reduce_a <= {PORT_W{1'b0}};
            reduce_b <= {PORT_W{1'b0}};
            reduce_e <= {PORT_W{1'b0}};
            reduce_k <= {PORT_W{1'b0}};
        end else begin
            reduce_a <= drv_gate(port_drive_strength[`PDCI_DRV_A], dir_a);
            reduce_b <= drv_gate(port_drive_strength[`PDCI_DRV_B], dir_b);
            reduce_e <= drv_gate(port_drive_strength[`PDCI_DRV_E], dir_e);
            reduce_k <= drv_gate(port_drive_strength[`PDCI_DRV_K], dir_k);
        end
    end

    // clock divider; a change of settings restarts from phase zero
    // limitation: divide by 1 cannot toggle faster than clk, so phase is high
    always @(posedge clk) begin
        if (sys_rst) begin
            div_cnt <= 5'h00;
            pre_cnt <= 4'h0;
            div_phase <= 1'b0;
            cfg_prev <= 6'h00;
        end else begin
            cfg_prev <= cfg_now;
            if (cfg_prev != cfg_now) begin
                div_cnt <= 5'h00;
                pre_cnt <= 4'h0;
                div_phase <= 1'b0;
            end else if (div_cnt == div_field) begin
                div_cnt <= 5'h00;
                if (!prescale_on || pre_cnt == `PDCI_PRESCALE_LAST) begin
                    pre_cnt <= 4'h0;
                    div_phase <= 1'b1;
                end else begin
                    pre_cnt <= pre_cnt + 4'h1;
                    div_phase <= 1'b0;
                end
            end else begin
                div_cnt <= div_cnt + 5'h01;
                div_phase <= 1'b0;
            end
        end
    end

    // shared pin: clock output wins over general I/O when enabled
    always @(posedge clk) begin
        if (sys_rst) begin
            bus_clock_out <= 1'b0;
            bus_clock_oe_n <= 1'b1;
            double_clock_en <= 1'b0;
        end else begin
            if (!clock_output_control[`PDCI_CLK_OFF]) begin
                bus_clock_out <= div_phase;
                bus_clock_oe_n <= 1'b0;
            end else begin
                bus_clock_out <= gpio_e4_out;
                bus_clock_oe_n <= !gpio_e4_dir;
            end
            // clk-rate register cannot make 2x; pad logic gates its doubler
            double_clock_en <= !clock_output_control[`PDCI_X2_OFF];
        end
    end

    // interrupt pin sampling and request
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
            edge_pending <= 1'b0;
        end else begin
            pin_meta <= irq_pin_n;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            // a new edge in the service cycle is kept
            if (edge_select && pin_connect && fall_seen) begin
                edge_pending <= 1'b1;
            end else if (irq_service || !edge_select) begin
                edge_pending <= 1'b0;
            end
        end
    end

    always @* begin
        if (!pin_connect) begin
            next_req = 1'b0;
        end else if (edge_select) begin
            next_req = edge_pending;
        end else begin
            next_req = !pin_sync;
        end
    end

    // sticky status: bit 0 edge latched, bit 1 level request; set beats clear
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_stat <= 2'h0;
            ext_irq_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_stat[`PDCI_ST_EDGE] <= (edge_select && pin_connect && fall_seen)
                || (irq_stat[`PDCI_ST_EDGE] && !(wr_stat && reg_wdata[`PDCI_ST_EDGE]));
            irq_stat[`PDCI_ST_LEVEL] <= (!edge_select && next_req)
                || (irq_stat[`PDCI_ST_LEVEL] && !(wr_stat && reg_wdata[`PDCI_ST_LEVEL]));
            ext_irq_req <= next_req;
            irq <= |(irq_stat & irq_mask);
        end
    end

endmodule
